// file: rtl/rrw_pkg.sv
package rrw_pkg;
	typedef logic [15:0] rrw_word_t;
	typedef logic [7:0] rrw_addr_t;
	typedef logic [1:0] rrw_method_t;
	typedef logic [12:0] rrw_result_t;
endpackage : rrw_pkg

// file: rtl/rrw_regs.svh
`ifndef RRW_REGS_SVH
`define RRW_REGS_SVH

// word addresses equal the identify word numbers
`define RRW_A_ERASE 8'h5A
`define RRW_A_APM 8'h5B
`define RRW_A_PWREV 8'h5C
`define RRW_A_RESULT 8'h5D
`define RRW_A_ACOUSTIC 8'h5E
`define RRW_A_STATUS 8'h60
`define RRW_A_MASK 8'h61

// fixed contents and reset values of the writable words
`define RRW_ERASE_TIME 16'h0000
`define RRW_ACOU_VENDOR 8'h80
`define RRW_APM_RST 16'h0000
`define RRW_PWREV_RST 16'hFFFE
`define RRW_ACOU_CUR_RST 8'h80

// result word layout
`define RRW_RES_LO_RST 13'h0100
`define RRW_B_CABLE 13
`define RRW_B_D1_PDIAG 11
`define RRW_B_ONE 8
`define RRW_B_D0_DASP 6
`define RRW_B_D0_PDIAG 5
`define RRW_B_D0_FAIL 3

// status and mask bits
`define RRW_ST_W 3
`define RRW_ST_DONE 0
`define RRW_ST_CABLE 1
`define RRW_ST_FAIL 2

`endif

// file: rtl/rrw_sync.sv
`timescale 1ns/1ps
module rrw_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	wire [W-1:0] differ = s2_r ^ s3_r;

	// a bit moves only once stages two and three agree
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s1_r <= RST;
			s2_r <= RST;
			s3_r <= RST;
			q <= RST;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q <= (q & differ) | (s3_r & ~differ);
		end
	end
endmodule : rrw_sync

// file: rtl/rrw_top.sv
`timescale 1ns/1ps
`include "rrw_regs.svh"
module rrw_top (
	input wire logic mclk,
	input wire logic reset_n,
	input wire rrw_pkg::rrw_addr_t addr,
	input wire rrw_pkg::rrw_word_t wdata,
	input wire logic wr,
	input wire logic rd,
	output rrw_pkg::rrw_word_t rdata,
	output logic irq,
	input wire logic hw_rst_busy,
	input wire logic diag_fail,
	input wire logic pdiag_drive,
	input wire logic dasp_n,
	input wire logic pdiag_n,
	input wire logic cbl_above_hi,
	input wire logic cbl_below_lo,
	input wire logic dev_second,
	input wire rrw_pkg::rrw_method_t num_method
);
	import rrw_pkg::*;

	logic dasp_n_s;
	logic pdiag_n_s;
	logic cbl_hi_s;
	logic cbl_lo_s;
	logic dev1_s;
	rrw_method_t meth_s;
	logic busy_d_r;
	logic dasp_seen_r;
	logic pdiag_seen_r;
	logic own_pdiag_r;
	logic cable_r;
	rrw_result_t res_r;
	rrw_result_t res_nxt;
	rrw_word_t apm_r;
	rrw_word_t pwrev_r;
	logic [7:0] acou_cur_r;
	logic [`RRW_ST_W-1:0] status_r;
	logic [`RRW_ST_W-1:0] mask_r;
	logic [`RRW_ST_W-1:0] status_nxt;

	// presence and diagnostic lines idle high (active low)
	rrw_sync #(.W(2), .RST(2'h3)) u_sync_lo (
		.mclk(mclk),
		.reset_n(reset_n),
		.d({dasp_n, pdiag_n}),
		.q({dasp_n_s, pdiag_n_s})
	);

	// cable comparators and device number straps idle low
	rrw_sync #(.W(5), .RST(5'h00)) u_sync_hi (
		.mclk(mclk),
		.reset_n(reset_n),
		.d({cbl_above_hi, cbl_below_lo, dev_second, num_method}),
		.q({cbl_hi_s, cbl_lo_s, dev1_s, meth_s})
	);

	// reset phase edges
	wire rst_start = hw_rst_busy & ~busy_d_r;
	wire rst_done = ~hw_rst_busy & busy_d_r;

	// reserved method 00 is never reported; unknown is used instead
	wire [1:0] meth_rep = (meth_s == 2'h0) ? 2'h3 : meth_s;

	// per-device halves of the result
	wire [4:0] d1_half = {1'b0, own_pdiag_r, meth_rep, 1'b1};
	wire [7:0] d0_half = {1'b0, dasp_seen_r, pdiag_seen_r, 1'b0, diag_fail,
		meth_rep, 1'b1};

	// the absent half reads zero; bit 8 is one for both devices
	always_comb begin
		res_nxt = dev1_s ? {d1_half, 8'h00} : {5'h01, d0_half};
	end

	// sampled outcomes gathered while the reset runs
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			busy_d_r <= 1'b0;
			dasp_seen_r <= 1'b0;
			pdiag_seen_r <= 1'b0;
			own_pdiag_r <= 1'b0;
		end else begin
			busy_d_r <= hw_rst_busy;
			if (rst_start) begin
				dasp_seen_r <= ~dasp_n_s;
				pdiag_seen_r <= ~pdiag_n_s;
				own_pdiag_r <= pdiag_drive;
			end else if (hw_rst_busy) begin
				dasp_seen_r <= dasp_seen_r | ~dasp_n_s;
				pdiag_seen_r <= pdiag_seen_r | ~pdiag_n_s;
				own_pdiag_r <= own_pdiag_r | pdiag_drive;
			end
		end
	end

	// result tracks only during reset, so the last value is the completion one
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			res_r <= `RRW_RES_LO_RST;
		end else if (hw_rst_busy) begin
			res_r <= res_nxt;
		end
	end

	// hysteresis: between thresholds the cable bit holds
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cable_r <= 1'b0;
		end else if (cbl_hi_s & ~cbl_lo_s) begin
			cable_r <= 1'b1;
		end else if (cbl_lo_s & ~cbl_hi_s) begin
			cable_r <= 1'b0;
		end
	end

	// register decode
	wire sel_apm = addr == `RRW_A_APM;
	wire sel_pwrev = addr == `RRW_A_PWREV;
	wire sel_acou = addr == `RRW_A_ACOUSTIC;
	wire sel_stat = addr == `RRW_A_STATUS;
	wire sel_mask = addr == `RRW_A_MASK;
	wire [15:0] word_result = {1'b0, 1'b1, cable_r, res_r};

	// read mux; unmapped addresses read zero
	wire [15:0] rd_mux =
		(addr == `RRW_A_ERASE) ? `RRW_ERASE_TIME :
		sel_apm ? apm_r :
		sel_pwrev ? pwrev_r :
		(addr == `RRW_A_RESULT) ? word_result :
		sel_acou ? {`RRW_ACOU_VENDOR, acou_cur_r} :
		sel_stat ? {13'h0000, status_r} :
		sel_mask ? {13'h0000, mask_r} : 16'h0000;

	// software-set levels, normally loaded by the feature command path
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			apm_r <= `RRW_APM_RST;
			pwrev_r <= `RRW_PWREV_RST;
			acou_cur_r <= `RRW_ACOU_CUR_RST;
			mask_r <= '0;
		end else if (wr) begin
			if (sel_apm) apm_r <= wdata;
			if (sel_pwrev) pwrev_r <= wdata;
			if (sel_acou) acou_cur_r <= wdata[7:0];
			if (sel_mask) mask_r <= wdata[`RRW_ST_W-1:0];
		end
	end

	// events: reset done, cable bit moved, diagnostics failed at done
	wire cable_evt = (cbl_hi_s & ~cbl_lo_s & ~cable_r) | (cbl_lo_s & ~cbl_hi_s & cable_r);
	wire [`RRW_ST_W-1:0] evt = {rst_done & ~dev1_s & res_r[`RRW_B_D0_FAIL], cable_evt, rst_done};
	wire [`RRW_ST_W-1:0] w1c = (wr & sel_stat) ? wdata[`RRW_ST_W-1:0] : '0;
	// mask at its next value, else irq would lag a mask write by one cycle
	wire [`RRW_ST_W-1:0] mask_nxt = (wr & sel_mask) ? wdata[`RRW_ST_W-1:0] : mask_r;

	// a new event beats a clear in the same cycle
	always_comb begin
		status_nxt = (status_r & ~w1c) | evt;
	end

	// status, interrupt and read data registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			status_r <= '0;
			irq <= 1'b0;
			rdata <= '0;
		end else begin
			status_r <= status_nxt;
			irq <= |(status_nxt & mask_nxt);
			rdata <= rd ? rd_mux : 16'h0000;
		end
	end

	sequence s_rd_result;
		rd && addr == `RRW_A_RESULT;
	endsequence
	sequence s_wr_acou;
		wr && sel_acou;
	endsequence
	sequence s_rd_acou;
		rd && sel_acou;
	endsequence

	property p_res_hold;
		@(posedge mclk) disable iff (!reset_n) !hw_rst_busy |=> res_r == $past(res_r);
	endproperty
	a_res_hold: assert property (p_res_hold) else $error("result changed outside reset");

	property p_fixed_bits;
		@(posedge mclk) disable iff (!reset_n)
			s_rd_result |=> rdata[15:14] == 2'h1 && rdata[8];
	endproperty
	a_fixed_bits: assert property (p_fixed_bits) else $error("fixed result bits wrong");

	property p_cable;
		@(posedge mclk) disable iff (!reset_n) cbl_hi_s && !cbl_lo_s |=> cable_r;
	endproperty
	a_cable: assert property (p_cable) else $error("cable bit not set");

	property p_d0_upper;
		@(posedge mclk) disable iff (!reset_n)
			hw_rst_busy && !dev1_s |=> res_r[12:8] == 5'h01;
	endproperty
	a_d0_upper: assert property (p_d0_upper) else $error("first device upper half");

	property p_d1_lower;
		@(posedge mclk) disable iff (!reset_n) hw_rst_busy && dev1_s |=> res_r[7:0] == 8'h00;
	endproperty
	a_d1_lower: assert property (p_d1_lower) else $error("second device lower half");

	property p_d1_pdiag;
		@(posedge mclk) disable iff (!reset_n)
			hw_rst_busy && dev1_s && pdiag_drive ##1 hw_rst_busy && dev1_s
			|=> res_r[`RRW_B_D1_PDIAG];
	endproperty
	a_d1_pdiag: assert property (p_d1_pdiag) else $error("own diagnostic line missed");

	property p_method;
		@(posedge mclk) disable iff (!reset_n) hw_rst_busy |=> res_r[10:9] != 2'h0 ||
			res_r[2:1] != 2'h0;
	endproperty
	a_method: assert property (p_method) else $error("reserved method reported");

	property p_dasp;
		@(posedge mclk) disable iff (!reset_n)
			hw_rst_busy && !dasp_n_s ##1 hw_rst_busy && !dev1_s |=> res_r[`RRW_B_D0_DASP];
	endproperty
	a_dasp: assert property (p_dasp) else $error("presence line missed");

	property p_fail;
		@(posedge mclk) disable iff (!reset_n)
			hw_rst_busy && !dev1_s |=> res_r[`RRW_B_D0_FAIL] == $past(diag_fail);
	endproperty
	a_fail: assert property (p_fail) else $error("diagnostic result wrong");

	property p_acou;
		@(posedge mclk) disable iff (!reset_n) s_wr_acou ##1 s_rd_acou
			|=> rdata == {`RRW_ACOU_VENDOR, $past(wdata[7:0], 2)};
	endproperty
	a_acou: assert property (p_acou) else $error("acoustic word wrong");

	property p_erase;
		@(posedge mclk) disable iff (!reset_n) rd && addr == `RRW_A_ERASE |=> rdata == `RRW_ERASE_TIME;
	endproperty
	a_erase: assert property (p_erase) else $error("erase time wrong");

	property p_irq;
		@(posedge mclk) disable iff (!reset_n) |(status_r & mask_r) |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

	property p_irq_low;
		@(posedge mclk) disable iff (!reset_n) (status_r & mask_r) == '0 |-> !irq;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("interrupt without pending event");

	property p_cable_clr;
		@(posedge mclk) disable iff (!reset_n) cbl_lo_s && !cbl_hi_s |=> !cable_r;
	endproperty
	a_cable_clr: assert property (p_cable_clr) else $error("cable bit not cleared");

	property p_d1_method;
		@(posedge mclk) disable iff (!reset_n)
			hw_rst_busy && dev1_s && meth_s != 2'h0 |=> res_r[10:9] == $past(meth_s);
	endproperty
	a_d1_method: assert property (p_d1_method) else $error("second method wrong");

	property p_d0_method;
		@(posedge mclk) disable iff (!reset_n)
			hw_rst_busy && !dev1_s && meth_s != 2'h0 |=> res_r[2:1] == $past(meth_s);
	endproperty
	a_d0_method: assert property (p_d0_method) else $error("first method wrong");

	property p_pdiag_seen;
		@(posedge mclk) disable iff (!reset_n)
			hw_rst_busy && !pdiag_n_s ##1 hw_rst_busy && !dev1_s |=> res_r[`RRW_B_D0_PDIAG];
	endproperty
	a_pdiag_seen: assert property (p_pdiag_seen) else $error("diag line missed");

	property p_apm;
		@(posedge mclk) disable iff (!reset_n) wr && sel_apm |=> apm_r == $past(wdata);
	endproperty
	a_apm: assert property (p_apm) else $error("power level not stored");

	property p_rd_idle;
		@(posedge mclk) disable iff (!reset_n) !rd |=> rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

	property p_done_set;
		@(posedge mclk) disable iff (!reset_n) rst_done |=> status_r[`RRW_ST_DONE];
	endproperty
	a_done_set: assert property (p_done_set) else $error("reset done not flagged");
endmodule : rrw_top

// file: test/rrw_peer.sv
`timescale 1ns/1ps
// other device on the cable: drives the shared open-drain handshake lines
module rrw_peer (
	input wire logic mclk,
	input wire logic want_dasp,
	input wire logic want_pdiag,
	output logic dasp_n,
	output logic pdiag_n
);
	// released lines float back to the pull-up level, never the last driven value
	always_ff @(posedge mclk) begin
		dasp_n <= ~want_dasp;
		pdiag_n <= ~want_pdiag;
	end
endmodule : rrw_peer

// file: test/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("Error %s expected %h seen %h", n, e, g); end end
module testbench;
	import rrw_pkg::*;
	logic mclk = 0, reset_n = 0, wr = 0, rd = 0, hw_rst_busy = 0, diag_fail = 0;
	logic pdiag_drive = 0, cbl_above_hi = 0, cbl_below_lo = 1, dev_second = 0;
	logic want_dasp = 0, want_pdiag = 0, irq, dasp_n, pdiag_n;
	rrw_addr_t addr = 8'h00;
	rrw_word_t wdata = 16'h0000, rdata, exp_res;
	rrw_method_t num_method = 2'h1;
	int mismatches = 0, comparisons = 0, cycles = 0;
	rrw_top DUT (.mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq(irq), .hw_rst_busy(hw_rst_busy),
		.diag_fail(diag_fail), .pdiag_drive(pdiag_drive), .dasp_n(dasp_n),
		.pdiag_n(pdiag_n), .cbl_above_hi(cbl_above_hi), .cbl_below_lo(cbl_below_lo),
		.dev_second(dev_second), .num_method(num_method));
	rrw_peer peer (.mclk(mclk), .want_dasp(want_dasp), .want_pdiag(want_pdiag),
		.dasp_n(dasp_n), .pdiag_n(pdiag_n));
	// 25 MHz
	always #20 mclk = ~mclk;
	// hang guard, well above the few hundred cycles the run needs
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_sim
	task automatic wr_reg(input rrw_addr_t a, input rrw_word_t d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	// read data stands only in the cycle after the strobe edge
	task automatic rd_chk(input rrw_addr_t a, input rrw_word_t e, input string n);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		`CHK(n, e, rdata)
	endtask : rd_chk
	// write then read with no gap between the strobes
	task automatic wr_rd_chk(input rrw_addr_t a, input rrw_word_t d, input rrw_word_t e,
		input string n);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		`CHK(n, e, rdata)
	endtask : wr_rd_chk
	// straps settle first, then a busy window with the peer driving its lines
	task automatic hw_reset(input logic pd, input logic pg);
		repeat (6) @(posedge mclk);
		hw_rst_busy <= 1'b1;
		want_dasp <= pd;
		want_pdiag <= pg;
		repeat (10) @(posedge mclk);
		hw_rst_busy <= 1'b0;
		want_dasp <= 1'b0;
		want_pdiag <= 1'b0;
		repeat (8) @(posedge mclk);
	endtask : hw_reset
	task automatic t_regs();
		rd_chk(8'h5A, 16'h0000, "erase");
		rd_chk(8'h5B, 16'h0000, "apm");
		rd_chk(8'h5C, 16'hFFFE, "rev");
		rd_chk(8'h5E, 16'h8080, "acou");
		rd_chk(8'h5D, 16'h4100, "res_rst");
		wr_reg(8'h5B, 16'h1234);
		wr_reg(8'h5C, 16'h00AB);
		wr_rd_chk(8'h5E, 16'hFF33, 16'h8033, "acou_b2b");
		wr_reg(8'h5A, 16'h5555);
		wr_reg(8'h07, 16'h5555);
		rd_chk(8'h5B, 16'h1234, "apm_w");
		rd_chk(8'h5C, 16'h00AB, "rev_w");
		rd_chk(8'h5E, 16'h8033, "acou_w");
		rd_chk(8'h5A, 16'h0000, "erase_ro");
		rd_chk(8'h07, 16'h0000, "unmapped");
	endtask : t_regs
	// first device with failed diagnostics, peer drives both lines; irq masked then unmasked
	task automatic t_first();
		wr_reg(8'h61, 16'h0000);
		dev_second <= 1'b0;
		num_method <= 2'h1;
		diag_fail <= 1'b1;
		hw_reset(1'b1, 1'b1);
		diag_fail <= 1'b0;
		exp_res = 16'h416B;
		rd_chk(8'h5D, exp_res, "res_first");
		`CHK("irq_masked", 1'b0, irq)
		rd_chk(8'h60, 16'h0005, "status");
		wr_reg(8'h61, 16'h0007);
		repeat (2) @(posedge mclk);
		`CHK("irq_on", 1'b1, irq)
		wr_reg(8'h60, 16'h0007);
		repeat (2) @(posedge mclk);
		`CHK("irq_off", 1'b0, irq)
		hw_reset(1'b0, 1'b0);
		exp_res = 16'h4103;
		rd_chk(8'h5D, exp_res, "res_quiet");
	endtask : t_first
	// second device, every method code, with and without own diagnostic drive
	task automatic t_second();
		for (int m = 0; m < 4; m++) begin
			dev_second <= 1'b1;
			num_method <= m[1:0];
			pdiag_drive <= m[0];
			hw_reset(1'b1, 1'b1);
			pdiag_drive <= 1'b0;
			exp_res = 16'h4100 | (16'(m[0]) << 11) | (16'((m == 0) ? 3 : m) << 9);
			rd_chk(8'h5D, exp_res, "res_second");
		end
	endtask : t_second
	// pins move without a busy window: the word must not follow
	task automatic t_hold();
		dev_second <= 1'b0;
		num_method <= 2'h2;
		diag_fail <= 1'b1;
		want_dasp <= 1'b1;
		repeat (10) @(posedge mclk);
		want_dasp <= 1'b0;
		diag_fail <= 1'b0;
		rd_chk(8'h5D, exp_res, "res_hold");
		rd_chk(8'h5D, exp_res, "res_again");
	endtask : t_hold
	// old reset-done flags cleared first, so only the cable event can raise irq
	task automatic t_cable();
		wr_reg(8'h60, 16'h0007);
		cbl_above_hi <= 1'b1;
		cbl_below_lo <= 1'b0;
		repeat (8) @(posedge mclk);
		rd_chk(8'h5D, exp_res | 16'h2000, "cable_hi");
		`CHK("irq_cable", 1'b1, irq)
		rd_chk(8'h60, 16'h0002, "status_cable");
		cbl_above_hi <= 1'b0;
		cbl_below_lo <= 1'b1;
		repeat (8) @(posedge mclk);
		rd_chk(8'h5D, exp_res, "cable_lo");
	endtask : t_cable
	initial begin
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		t_regs();
		t_first();
		t_second();
		t_hold();
		t_cable();
		end_sim();
	end
endmodule : testbench
